// ---- npc_array_model.sv ----
`default_nettype none
module npc_array_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Array port
	input  wire logic        arr_stb_i,
	input  wire logic        arr_erase_i,
	input  wire logic [1:0]  arr_space_i,
	input  wire logic [15:0] arr_addr_i,
	input  wire logic [7:0]  arr_wdata_i,
	input  wire logic        slow_i,
	output logic             arr_ack_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  fl [0:4095];
	logic [7:0]  ee [0:255];
	logic [7:0]  ur [0:63];
	logic        pend;
	logic        er;
	logic [1:0]  sp;
	logic [15:0] ad;
	logic [7:0]  wd;
	int          cnt;

	// Cells start programmed, so a write without an erase first leaves damage
	initial begin
		foreach (fl[i]) fl[i] = 8'h00;
		foreach (ee[i]) ee[i] = 8'h00;
		foreach (ur[i]) ur[i] = 8'h00;
		arr_ack_o = 1'h0;
		pend = 1'h0;
	end

	// Programming can only clear bits, like a real cell
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend <= 1'h0;
			arr_ack_o <= 1'h0;
			cnt <= 0;
		end else begin
			arr_ack_o <= 1'h0;
			if (arr_stb_i) begin
				pend <= 1'h1;
				cnt <= slow_i ? 6 : 0;
				{er, sp, ad, wd} <= {arr_erase_i, arr_space_i, arr_addr_i, arr_wdata_i};
			end else if (pend && cnt != 0) begin
				cnt <= cnt - 1;
			end else if (pend) begin
				pend <= 1'h0;
				arr_ack_o <= 1'h1;
				case (sp)
					2'h0: begin
						if (er) begin
							for (int i = 0; i < 64; i++) fl[{ad[11:6], i[5:0]}] = 8'hff;
						end else begin
							fl[ad[11:0]] = fl[ad[11:0]] & wd;
						end
					end
					2'h1: ee[ad[7:0]] = er ? 8'hff : ee[ad[7:0]] & wd;
					default: ur[ad[5:0]] = er ? 8'hff : ur[ad[5:0]] & wd;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- npc_defines.svh ----
`ifndef NPC_DEFINES_SVH
`define NPC_DEFINES_SVH

`define NPC_ADDR_W      16
`define NPC_FUSE_W      8
`define NPC_PAGE_BYTES  64
`define NPC_IDX_W       6
`define NPC_IDX_LAST    6'h3f
`define NPC_BLOCK_SHIFT 8
`define NPC_SPM_KEY     8'h9d
`define NPC_CCP_SPAN    3'h4
`define NPC_CLR_CYCLES  3'h7
`define NPC_CMD_NOP     3'h0
`define NPC_CMD_WP      3'h1
`define NPC_CMD_ER      3'h2
`define NPC_CMD_WIPE_THEN_PROGRAM_CMD    3'h3
`define NPC_CMD_PBC     3'h4
`define NPC_CMD_CHER    3'h5
`define NPC_CMD_EEER    3'h6
`define NPC_CMD_WFU     3'h7
`define NPC_SP_FLASH    2'h0
`define NPC_SP_EEPROM   2'h1
`define NPC_SP_USER     2'h2

`endif

// ---- npc_page_buf.sv ----
`default_nettype none
`include "npc_defines.svh"
module npc_page_buf
	import npc_pkg::*;
(
	// Clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	// Controller side
	npc_pbuf_if.store   pb
);

	npc_pbuf_st_t s_r;
	npc_pbuf_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		// Clear wins over a store landing in the same cycle
		if (pb.clr) begin
			s_nxt.data = '1;
			s_nxt.mark = '0;
		end else if (pb.wr) begin
			s_nxt.data[pb.idx] = s_r.data[pb.idx] & pb.wdata;
			s_nxt.mark[pb.idx] = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r.data <= '1;
			s_r.mark <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pb.rd_data  = s_r.data[pb.rd_idx];
	assign pb.rd_mark  = s_r.mark[pb.rd_idx];
	assign pb.any_mark = |s_r.mark;

	chk_and_merge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pb.wr && !pb.clr) |=> s_r.data[$past(pb.idx)]
			== ($past(s_r.data[pb.idx]) & $past(pb.wdata)))
		else $error("page buffer store is not an AND merge");

	chk_clear_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pb.clr |=> (&s_r.data) && !pb.any_mark)
		else $error("page buffer not all ones after clear");

endmodule
`default_nettype wire

// ---- npc_page_ctrl.sv ----
// Overview of operation
// - Flash: program or erase whole pages only
// - Loader section ends at loader fuse times 256
// - Program section up to program fuse times 256
// - Program fuse zero: program runs to end
// - Both fuses zero: all flash is loader
// - Writes only flow to lower-privilege sections
// - Core never writes the loader section
// - Lock bits stay set until reset
// - Loader lock blocks reads and fetches there
// - EEPROM touches only marked buffer bytes
// - User row behaves as an EEPROM page
// - Reads wait while an array is busy
// - Stores AND-merge into shared page buffer
// - Buffer all ones after reset, ops, clear, wake
// - Buffer set to ones on sleep entry
// - Page write copies buffer, halts for flash
// - Erase needs a marked byte, halts for flash
// - EEPROM erase only marked bytes, no halt
// - Erase then write without clearing the buffer
// - Buffer clear halts core seven cycles
// - Three-bit command code decode
// - Unlock key opens four-instruction window
// - Busy flags for flash and EEPROM
`default_nettype none
`include "npc_defines.svh"
module npc_page_ctrl
	import npc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	// Section fuses
	input  wire logic [`NPC_FUSE_W-1:0] loader_end_fuse_i,
	input  wire logic [`NPC_FUSE_W-1:0] program_end_fuse_i,
	// Core access
	input  wire logic                   cpu_req_i,
	input  wire logic                   cpu_we_i,
	input  wire logic [1:0]             cpu_space_i,
	input  wire logic [`NPC_ADDR_W-1:0] cpu_addr_i,
	input  wire logic [7:0]             cpu_wdata_i,
	input  wire logic [`NPC_ADDR_W-1:0] cpu_pc_i,
	input  wire logic                   instr_done_i,
	// Protection and commands
	input  wire logic                   ccp_wr_i,
	input  wire logic [7:0]             ccp_data_i,
	input  wire logic                   cmd_wr_i,
	input  wire logic [2:0]             cmd_i,
	input  wire logic                   lock_wr_i,
	input  wire logic                   lock_loader_i,
	input  wire logic                   lock_program_i,
	// Power
	input  wire logic                   sleep_enter_i,
	input  wire logic                   wake_i,
	// Array port
	input  wire logic                   arr_ack_i,
	output logic                        arr_stb_o,
	output logic                        arr_erase_o,
	output logic [1:0]                  arr_space_o,
	output logic [`NPC_ADDR_W-1:0]      arr_addr_o,
	output logic [7:0]                  arr_wdata_o,
	// Status
	output logic                        flash_busy_flag_o,
	output logic                        eeprom_busy_flag_o,
	output logic                        write_error_o,
	output logic                        cpu_wait_o,
	output logic                        cpu_halt_o,
	output logic                        rd_zero_o,
	output logic                        fetch_zero_o,
	output logic                        loader_read_lock_o,
	output logic                        program_write_guard_o,
	output logic                        spm_open_o
);

	npc_ctrl_st_t s_r;
	npc_ctrl_st_t s_nxt;
	npc_pbuf_if   pb ();

	logic                  acc_op;
	logic                  acc_clr;
	logic                  adv;
	logic                  need;
	logic                  pb_wr;
	logic                  pb_clr;
	npc_sect_t             exec_sec;
	npc_sect_t             tgt_sec;
	npc_sect_t             rd_sec;
	npc_cmd_t              cmd;
	npc_space_t            cpu_space;

	function automatic npc_sect_t sect_of(input logic [`NPC_ADDR_W-1:0] a,
		input logic [`NPC_FUSE_W-1:0] bf, input logic [`NPC_FUSE_W-1:0] af);
		logic [`NPC_ADDR_W-1:0] be;
		logic [`NPC_ADDR_W-1:0] ae;
		be = `NPC_ADDR_W'(bf) << `NPC_BLOCK_SHIFT;
		ae = `NPC_ADDR_W'(af) << `NPC_BLOCK_SHIFT;
		if (bf == '0 && af == '0) begin
			return SEC_LOADER;
		end
		if (a < be) begin
			return SEC_LOADER;
		end
		if (af == '0 || a < ae) begin
			return SEC_PROGRAM;
		end
		return SEC_DATA;
	endfunction

	function automatic logic wr_allowed(input npc_space_t sp, input npc_sect_t tgt,
		input npc_sect_t ex, input logic guard);
		if (ex == SEC_DATA) begin
			return 1'b0;
		end
		if (sp != SP_FLASH) begin
			return 1'b1;
		end
		unique case (tgt)
			SEC_LOADER:  return 1'b0;
			SEC_PROGRAM: return ex == SEC_LOADER && !guard;
			SEC_DATA:    return 1'b1;
		endcase
		return 1'b0;
	endfunction

	assign cmd       = npc_cmd_t'(cmd_i);
	assign cpu_space = npc_space_t'(cpu_space_i);
	assign exec_sec  = sect_of(cpu_pc_i, s_r.boot_f, s_r.app_f);
	assign tgt_sec   = sect_of(s_r.page, s_r.boot_f, s_r.app_f);
	assign rd_sec    = sect_of(cpu_addr_i, s_r.boot_f, s_r.app_f);

	always_comb begin
		s_nxt   = s_r;
		acc_op  = 1'b0;
		acc_clr = 1'b0;
		adv     = 1'b0;
		need    = 1'b0;
		pb_wr   = 1'b0;
		pb_clr  = 1'b0;
		s_nxt.arr_stb = 1'b0;

		// Fuses are static straps; caught once just after reset release
		if (!s_r.fuse_ok) begin
			s_nxt.boot_f  = loader_end_fuse_i;
			s_nxt.app_f   = program_end_fuse_i;
			s_nxt.fuse_ok = 1'b1;
		end

		// Any array access, sleep or command write closes the window
		if (ccp_wr_i && ccp_data_i == `NPC_SPM_KEY) begin
			s_nxt.ccp_cnt = `NPC_CCP_SPAN;
		end else if (cpu_req_i || sleep_enter_i || cmd_wr_i) begin
			s_nxt.ccp_cnt = '0;
		end else if (instr_done_i && s_r.ccp_cnt != '0) begin
			s_nxt.ccp_cnt = s_r.ccp_cnt - 3'h1;
		end

		if (lock_wr_i && lock_program_i) begin
			s_nxt.lock_prog = 1'b1;
		end
		if (lock_wr_i && lock_loader_i && exec_sec == SEC_LOADER) begin
			s_nxt.lock_boot_arm = 1'b1;
		end
		// Loader lock bites only once execution has left the loader
		if (s_r.lock_boot_arm && exec_sec != SEC_LOADER) begin
			s_nxt.lock_boot = 1'b1;
		end
		s_nxt.rd_zero = cpu_req_i && !cpu_we_i && cpu_space == SP_FLASH
			&& s_r.lock_boot && rd_sec == SEC_LOADER;
		s_nxt.fetch_zero = s_r.lock_boot && exec_sec == SEC_LOADER;

		unique case (s_r.st)
			ST_IDLE: begin
				if (cpu_req_i && cpu_we_i && s_r.fuse_ok) begin
					pb_wr       = 1'b1;
					s_nxt.space = cpu_space;
					s_nxt.page  = cpu_addr_i & ~`NPC_ADDR_W'(`NPC_IDX_LAST);
				end
				if (cmd_wr_i && s_r.ccp_cnt != '0 && s_r.fuse_ok) begin
					unique case (cmd)
						CMD_WP, CMD_ER, CMD_WIPE_THEN_PROGRAM_CMD: begin
							if (wr_allowed(s_r.space, tgt_sec, exec_sec, s_r.lock_prog)
								&& (cmd != CMD_ER || pb.any_mark)) begin
								acc_op          = 1'b1;
								s_nxt.wr_err    = 1'b0;
								s_nxt.st        = ST_STEP;
								s_nxt.idx       = '0;
								s_nxt.op_prog   = cmd == CMD_WP;
								s_nxt.then_prog = cmd == CMD_WIPE_THEN_PROGRAM_CMD;
								s_nxt.fl_busy   = s_r.space == SP_FLASH;
								s_nxt.ee_busy   = s_r.space != SP_FLASH;
								s_nxt.halt      = s_r.space == SP_FLASH;
							end else begin
								s_nxt.wr_err = 1'b1;
							end
						end
						CMD_PBC: begin
							acc_clr       = 1'b1;
							s_nxt.st      = ST_CLEAR;
							s_nxt.clr_cnt = `NPC_CLR_CYCLES;
							s_nxt.halt    = 1'b1;
						end
						CMD_NOP, CMD_CHER, CMD_EEER, CMD_WFU: begin
						end
					endcase
				end
				if (sleep_enter_i || wake_i) begin
					pb_clr = 1'b1;
				end
			end
			ST_STEP: begin
				// Flash erases the whole page with one strobe; flash writes every byte
				if (s_r.space == SP_FLASH) begin
					need = s_r.op_prog || s_r.idx == '0;
				end else begin
					need = pb.rd_mark;
				end
				if (need) begin
					s_nxt.arr_stb   = 1'b1;
					s_nxt.arr_erase = !s_r.op_prog;
					s_nxt.arr_addr  = s_r.page | `NPC_ADDR_W'(s_r.idx);
					s_nxt.arr_wdata = pb.rd_data;
					s_nxt.st        = ST_WAIT;
				end else begin
					adv = 1'b1;
				end
			end
			ST_WAIT: begin
				adv = arr_ack_i;
			end
			ST_CLEAR: begin
				s_nxt.clr_cnt = s_r.clr_cnt - 3'h1;
				if (s_r.clr_cnt == 3'h1) begin
					pb_clr     = 1'b1;
					s_nxt.halt = 1'b0;
					s_nxt.st   = ST_IDLE;
				end
			end
		endcase

		if (adv) begin
			if (s_r.idx != `NPC_IDX_LAST) begin
				s_nxt.idx = s_r.idx + `NPC_IDX_W'(1);
				s_nxt.st  = ST_STEP;
			end else if (!s_r.op_prog && s_r.then_prog) begin
				// Second phase reuses the same buffer contents
				s_nxt.op_prog = 1'b1;
				s_nxt.idx     = '0;
				s_nxt.st      = ST_STEP;
			end else begin
				pb_clr        = 1'b1;
				s_nxt.fl_busy = 1'b0;
				s_nxt.ee_busy = 1'b0;
				s_nxt.halt    = 1'b0;
				s_nxt.st      = ST_IDLE;
			end
		end

		s_nxt.wait_st  = s_nxt.fl_busy || s_nxt.ee_busy || s_nxt.halt;
		s_nxt.spm_open = s_nxt.ccp_cnt != '0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '{st: ST_IDLE, space: SP_FLASH, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pb.wr     = pb_wr;
	assign pb.idx    = cpu_addr_i[`NPC_IDX_W-1:0];
	assign pb.wdata  = cpu_wdata_i;
	assign pb.clr    = pb_clr;
	assign pb.rd_idx = s_r.idx;

	npc_page_buf u_buf (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pb      (pb)
	);

	assign arr_stb_o             = s_r.arr_stb;
	assign arr_erase_o           = s_r.arr_erase;
	assign arr_space_o           = s_r.space;
	assign arr_addr_o            = s_r.arr_addr;
	assign arr_wdata_o           = s_r.arr_wdata;
	assign flash_busy_flag_o     = s_r.fl_busy;
	assign eeprom_busy_flag_o    = s_r.ee_busy;
	assign write_error_o         = s_r.wr_err;
	assign cpu_wait_o            = s_r.wait_st;
	assign cpu_halt_o            = s_r.halt;
	assign rd_zero_o             = s_r.rd_zero;
	assign fetch_zero_o          = s_r.fetch_zero;
	assign loader_read_lock_o    = s_r.lock_boot;
	assign program_write_guard_o = s_r.lock_prog;
	assign spm_open_o            = s_r.spm_open;

	chk_busy_next_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		acc_op |=> (flash_busy_flag_o || eeprom_busy_flag_o) && cpu_wait_o)
		else $error("busy flag missing after accepted command");

	chk_clear_seven: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		acc_clr |=> cpu_halt_o [*7] ##1 !cpu_halt_o)
		else $error("buffer clear halt is not seven cycles");

	chk_guard_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		program_write_guard_o |=> program_write_guard_o)
		else $error("program write guard dropped without reset");

	chk_loader_never: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(acc_op && s_r.space == SP_FLASH) |-> tgt_sec != SEC_LOADER)
		else $error("write accepted into loader section");

	chk_data_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		acc_op |-> exec_sec != SEC_DATA)
		else $error("data section code started a write");

	chk_erase_marked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(acc_op && cmd == CMD_ER) |-> pb.any_mark)
		else $error("erase accepted with empty buffer");

	chk_key_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(flash_busy_flag_o || eeprom_busy_flag_o) |-> $past(spm_open_o))
		else $error("command accepted outside unlock window");

	chk_flash_halts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flash_busy_flag_o |-> cpu_halt_o)
		else $error("flash operation without core halt");

	chk_eeprom_runs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eeprom_busy_flag_o |-> !cpu_halt_o)
		else $error("core halted during EEPROM operation");

	chk_done_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(flash_busy_flag_o || eeprom_busy_flag_o) |-> !pb.any_mark)
		else $error("buffer not cleared when operation ended");

	chk_read_waits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(flash_busy_flag_o || eeprom_busy_flag_o) |-> cpu_wait_o)
		else $error("no wait while array busy");

	chk_stb_acked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		arr_stb_o |=> !arr_stb_o throughout (s_r.st == ST_WAIT)[*1])
		else $error("array strobe repeated while waiting");

endmodule
`default_nettype wire

// ---- npc_page_ctrl_tb.sv ----
`default_nettype none
module npc_page_ctrl_tb
	import npc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i              = 1'h0;
	logic        rst_n_i            = 1'h0;
	logic [7:0]  loader_end_fuse_i  = 8'h04;
	logic [7:0]  program_end_fuse_i = 8'h08;
	logic        cpu_req_i          = 1'h0;
	logic        cpu_we_i           = 1'h0;
	logic [1:0]  cpu_space_i        = 2'h0;
	logic [15:0] cpu_addr_i         = 16'h0000;
	logic [7:0]  cpu_wdata_i        = 8'h00;
	logic [15:0] cpu_pc_i           = 16'h0010;
	logic        instr_done_i       = 1'h0;
	logic        ccp_wr_i           = 1'h0;
	logic [7:0]  ccp_data_i         = 8'h00;
	logic        cmd_wr_i           = 1'h0;
	logic [2:0]  cmd_i              = 3'h0;
	logic        lock_wr_i          = 1'h0;
	logic        lock_loader_i      = 1'h0;
	logic        lock_program_i     = 1'h0;
	logic        sleep_enter_i      = 1'h0;
	logic        wake_i             = 1'h0;
	logic        slow               = 1'h0;
	logic        arr_ack_i, arr_stb_o, arr_erase_o;
	logic [1:0]  arr_space_o;
	logic [15:0] arr_addr_o;
	logic [7:0]  arr_wdata_o;
	logic        flash_busy_flag_o, eeprom_busy_flag_o, write_error_o, cpu_wait_o, cpu_halt_o;
	logic        rd_zero_o, fetch_zero_o, loader_read_lock_o, program_write_guard_o, spm_open_o;
	int          failures           = 0;
	int          total_checks       = 0;

	always #4 clk_i = ~clk_i;

	npc_page_ctrl u_npc_page_ctrl (
		.clk_i, .rst_n_i, .loader_end_fuse_i, .program_end_fuse_i,
		.cpu_req_i, .cpu_we_i, .cpu_space_i, .cpu_addr_i, .cpu_wdata_i, .cpu_pc_i,
		.instr_done_i, .ccp_wr_i, .ccp_data_i, .cmd_wr_i, .cmd_i, .lock_wr_i,
		.lock_loader_i, .lock_program_i, .sleep_enter_i, .wake_i, .arr_ack_i,
		.arr_stb_o, .arr_erase_o, .arr_space_o, .arr_addr_o, .arr_wdata_o,
		.flash_busy_flag_o, .eeprom_busy_flag_o, .write_error_o, .cpu_wait_o,
		.cpu_halt_o, .rd_zero_o, .fetch_zero_o, .loader_read_lock_o,
		.program_write_guard_o, .spm_open_o
	);

	npc_array_model u_npc_array_model (
		.clk_i, .rst_n_i, .arr_stb_i(arr_stb_o), .arr_erase_i(arr_erase_o),
		.arr_space_i(arr_space_o), .arr_addr_i(arr_addr_o), .arr_wdata_i(arr_wdata_o),
		.slow_i(slow), .arr_ack_o(arr_ack_i)
	);

	function automatic logic [7:0] fm(input logic [11:0] a);
		return u_npc_array_model.fl[a];
	endfunction

	function automatic logic [7:0] em(input logic [7:0] a);
		return u_npc_array_model.ee[a];
	endfunction

	task automatic end_of_test();
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic fail(input string msg);
		failures++;
		$display("ERROR %0t %s", $time, msg);
	endtask

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'h1) begin
			fail(msg);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic set_pc(input logic [15:0] a);
		@(posedge clk_i);
		cpu_pc_i <= a;
	endtask

	task automatic access(input logic we, input logic [1:0] sp, input logic [15:0] a,
			input logic [7:0] d);
		@(posedge clk_i);
		cpu_req_i <= 1'h1;
		cpu_we_i <= we;
		cpu_space_i <= sp;
		cpu_addr_i <= a;
		cpu_wdata_i <= d;
		@(posedge clk_i);
		cpu_req_i <= 1'h0;
	endtask

	task automatic command(input logic [7:0] key, input int gap, input logic [2:0] c);
		@(posedge clk_i);
		ccp_wr_i <= 1'h1;
		ccp_data_i <= key;
		@(posedge clk_i);
		ccp_wr_i <= 1'h0;
		repeat (gap) begin
			instr_done_i <= 1'h1;
			@(posedge clk_i);
		end
		instr_done_i <= 1'h0;
		cmd_wr_i <= 1'h1;
		cmd_i <= c;
		@(posedge clk_i);
		cmd_wr_i <= 1'h0;
	endtask

	task automatic wait_idle();
		#1;
		repeat (3000) begin
			if (flash_busy_flag_o === 1'h1 && cpu_wait_o !== 1'h1) begin
				fail("core not held during flash operation");
			end
			if (cpu_wait_o === 1'h0) begin
				return;
			end
			tick(1);
		end
		fail("controller stuck busy");
		end_of_test();
	endtask

	// Expected {flash busy, eeprom busy, halt, write error}
	task automatic op(input logic [2:0] c, input logic [3:0] e);
		wait_idle();
		command(8'h9d, 1, c);
		tick(1);
		chk({flash_busy_flag_o, eeprom_busy_flag_o, cpu_halt_o} === e[3:1], "busy flags");
		wait_idle();
		chk(write_error_o === e[0], "write error flag");
	endtask

	task automatic pulse_power(input logic s);
		@(posedge clk_i);
		sleep_enter_i <= s;
		wake_i <= ~s;
		@(posedge clk_i);
		sleep_enter_i <= 1'h0;
		wake_i <= 1'h0;
	endtask

	task automatic set_lock(input logic l, input logic p);
		@(posedge clk_i);
		lock_wr_i <= 1'h1;
		lock_loader_i <= l;
		lock_program_i <= p;
		@(posedge clk_i);
		lock_wr_i <= 1'h0;
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'h1;
		tick(2);
		chk({flash_busy_flag_o, eeprom_busy_flag_o, cpu_wait_o, write_error_o,
			loader_read_lock_o, program_write_guard_o, arr_stb_o} === 7'h00, "reset state");
	endtask

	task automatic t_flash_write();
		set_pc(16'h0010);
		access(1'h1, 2'h0, 16'h0440, 8'h00);
		op(CMD_ER, 4'ha);
		chk(fm(12'h47f) === 8'hff && fm(12'h480) === 8'h00, "erase span");
		access(1'h1, 2'h0, 16'h0440, 8'h5a);
		access(1'h1, 2'h0, 16'h0440, 8'hf0);
		access(1'h1, 2'h0, 16'h047f, 8'h81);
		op(CMD_WP, 4'ha);
		chk(fm(12'h440) === 8'h50, "merged byte");
		chk(fm(12'h47f) === 8'h81 && fm(12'h441) === 8'hff, "page write");
		op(CMD_ER, 4'h1);
	endtask

	task automatic t_eeprom();
		access(1'h1, 2'h1, 16'h0005, 8'h33);
		op(CMD_ER, 4'h4);
		chk(em(8'h05) === 8'hff && em(8'h06) === 8'h00, "marked erase");
		access(1'h1, 2'h1, 16'h0005, 8'h3c);
		op(CMD_WP, 4'h4);
		chk(em(8'h05) === 8'h3c && em(8'h06) === 8'h00, "marked write");
		access(1'h1, 2'h2, 16'h0001, 8'h77);
		op(CMD_WIPE_THEN_PROGRAM_CMD, 4'h4);
		chk(u_npc_array_model.ur[1] === 8'h77 && u_npc_array_model.ur[2] === 8'h00,
			"user row");
	endtask

	task automatic t_wipe_then_program_cmd_slow();
		set_pc(16'h07ff);
		slow <= 1'h1;
		access(1'h1, 2'h0, 16'h0850, 8'ha5);
		op(CMD_WIPE_THEN_PROGRAM_CMD, 4'ha);
		chk(fm(12'h850) === 8'ha5 && fm(12'h851) === 8'hff, "erase then write");
		slow <= 1'h0;
	endtask

	task automatic t_clear();
		int n;
		n = 0;
		set_pc(16'h0010);
		access(1'h1, 2'h0, 16'h0440, 8'h00);
		wait_idle();
		command(8'h9d, 1, CMD_PBC);
		// Halt rises on the edge that takes the command, so look from there
		#1;
		repeat (12) begin
			if (cpu_halt_o === 1'h1) begin
				n++;
			end
			tick(1);
		end
		chk(n == 7, "clear halt length");
		op(CMD_ER, 4'h1);
		access(1'h1, 2'h0, 16'h0440, 8'h00);
		pulse_power(1'h1);
		op(CMD_ER, 4'h1);
		access(1'h1, 2'h0, 16'h0440, 8'h00);
		pulse_power(1'h0);
		op(CMD_ER, 4'h1);
	endtask

	task automatic t_window();
		logic [2:0] codes [4] = '{CMD_NOP, CMD_CHER, CMD_EEER, CMD_WFU};
		command(8'h9d, 4, CMD_PBC);
		tick(2);
		chk(cpu_halt_o === 1'h0, "expired window");
		command(8'h9c, 1, CMD_PBC);
		tick(2);
		chk(cpu_halt_o === 1'h0, "wrong key");
		chk(spm_open_o === 1'h0, "window stays shut");
		command(8'h9d, 3, CMD_PBC);
		tick(1);
		chk(cpu_halt_o === 1'h1, "last slot of window");
		foreach (codes[i]) begin
			wait_idle();
			command(8'h9d, 1, codes[i]);
			tick(2);
			chk({flash_busy_flag_o, eeprom_busy_flag_o, cpu_halt_o} === 3'h0, "ignored code");
		end
	endtask

	task automatic t_protect();
		logic z;
		set_pc(16'h0400);
		access(1'h1, 2'h0, 16'h0440, 8'h00);
		op(CMD_WP, 4'h1);
		chk(fm(12'h440) === 8'h50, "guarded page kept");
		set_pc(16'h0800);
		access(1'h1, 2'h1, 16'h0007, 8'h00);
		op(CMD_WP, 4'h1);
		set_pc(16'h03ff);
		access(1'h1, 2'h0, 16'h0020, 8'h00);
		op(CMD_ER, 4'h1);
		access(1'h1, 2'h0, 16'h07c0, 8'h00);
		op(CMD_ER, 4'ha);
		set_lock(1'h0, 1'h1);
		tick(1);
		chk(program_write_guard_o === 1'h1, "guard set");
		access(1'h1, 2'h0, 16'h0440, 8'h00);
		op(CMD_ER, 4'h1);
		set_lock(1'h1, 1'h0);
		set_pc(16'h0500);
		tick(2);
		chk(loader_read_lock_o === 1'h1, "loader lock armed");
		access(1'h0, 2'h0, 16'h0030, 8'h00);
		#1;
		z = rd_zero_o;
		tick(1);
		z = z | rd_zero_o;
		chk(z === 1'h1, "locked load");
		set_pc(16'h0020);
		tick(2);
		chk(fetch_zero_o === 1'h1, "locked fetch");
		set_pc(16'h0010);
		do_reset();
	endtask

	initial begin
		do_reset();
		t_flash_write();
		t_eeprom();
		t_wipe_then_program_cmd_slow();
		t_clear();
		t_window();
		t_protect();
		end_of_test();
	end
endmodule
`default_nettype wire

// ---- npc_pbuf_if.sv ----
`default_nettype none
`include "npc_defines.svh"
interface npc_pbuf_if;
	logic                  wr;
	logic [`NPC_IDX_W-1:0] idx;
	logic [7:0]            wdata;
	logic                  clr;
	logic [`NPC_IDX_W-1:0] rd_idx;
	logic [7:0]            rd_data;
	logic                  rd_mark;
	logic                  any_mark;

	modport ctrl (output wr, idx, wdata, clr, rd_idx, input rd_data, rd_mark, any_mark);
	modport store (input wr, idx, wdata, clr, rd_idx, output rd_data, rd_mark, any_mark);
endinterface
`default_nettype wire

// ---- npc_pkg.sv ----
`default_nettype none
`include "npc_defines.svh"
package npc_pkg;

	typedef enum logic [2:0] {
		CMD_NOP  = `NPC_CMD_NOP,
		CMD_WP   = `NPC_CMD_WP,
		CMD_ER   = `NPC_CMD_ER,
		CMD_WIPE_THEN_PROGRAM_CMD = `NPC_CMD_WIPE_THEN_PROGRAM_CMD,
		CMD_PBC  = `NPC_CMD_PBC,
		CMD_CHER = `NPC_CMD_CHER,
		CMD_EEER = `NPC_CMD_EEER,
		CMD_WFU  = `NPC_CMD_WFU
	} npc_cmd_t;

	typedef enum logic [1:0] {
		SP_FLASH  = `NPC_SP_FLASH,
		SP_EEPROM = `NPC_SP_EEPROM,
		SP_USER   = `NPC_SP_USER
	} npc_space_t;

	typedef enum logic [1:0] {SEC_LOADER, SEC_PROGRAM, SEC_DATA} npc_sect_t;

	typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_WAIT, ST_CLEAR} npc_state_t;

	typedef struct packed {
		logic [`NPC_PAGE_BYTES-1:0][7:0] data;
		logic [`NPC_PAGE_BYTES-1:0]      mark;
	} npc_pbuf_st_t;

	typedef struct packed {
		npc_state_t             st;
		logic                   op_prog;
		logic                   then_prog;
		npc_space_t             space;
		logic [`NPC_ADDR_W-1:0] page;
		logic [`NPC_IDX_W-1:0]  idx;
		logic [2:0]             clr_cnt;
		logic [2:0]             ccp_cnt;
		logic                   fuse_ok;
		logic [`NPC_FUSE_W-1:0] boot_f;
		logic [`NPC_FUSE_W-1:0] app_f;
		logic                   lock_prog;
		logic                   lock_boot_arm;
		logic                   lock_boot;
		logic                   fl_busy;
		logic                   ee_busy;
		logic                   halt;
		logic                   wait_st;
		logic                   wr_err;
		logic                   arr_stb;
		logic                   arr_erase;
		logic [`NPC_ADDR_W-1:0] arr_addr;
		logic [7:0]             arr_wdata;
		logic                   rd_zero;
		logic                   fetch_zero;
		logic                   spm_open;
	} npc_ctrl_st_t;

endpackage
`default_nettype wire
